//--- hw/sbfm_fault_manager.sv
// Purpose: Fault supervision, interrupt and recovery sequencing for supply and boost.
// Assumes: Detector inputs are synchronous levels; Wishbone classic slave.
// Notes:   One ack cycle after each strobe; unmapped addresses ack with zero data.
//          Writes land on the edge that raises ack.
//          Bench may shorten both timing parameters.
//
// Functional notes
// - Input undervoltage: flag, standby, restart when recovered.
// - Input overvoltage: flag, interrupt, recover, wait low.
// - Regulator undervoltage: flag, interrupt, restart when recovered.
// - Input overcurrent: flag, interrupt, recover, restart later.
// - Charge pump fault: flag, interrupt, recover, delayed restart.
// - Missing pump parts: flag, interrupt, pump off.
// - Lost sync clock: flag, interrupt, internal clock.
// - Configuration load error: flag, interrupt, keep running.
// - Low overvoltage: flag only, pause boost switching.
// - High overvoltage: flag, interrupt, recover, wait low.
// - Feedback low 110 ms: boost overcurrent fault.
// - Bad string resistor: flag, six channels, full current.
// - Bad mode resistor: flag, phase-shift, default address.
// - Bad frequency resistor: flag, default for each bad frequency.
// - Recovery holds outputs off, restart needs enable, brightness.
// - Resistor checks only at initialization, choice kept.
`timescale 1ns/1ps
module sbfm_fault_manager #(
    parameter int unsigned RecoveryCycles = sbfm_pkg::RecoveryCyc,
    parameter int unsigned OcpQualCycles  = sbfm_pkg::OcpQualCyc
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Detector levels
    input  wire logic        inUndervoltage,
    input  wire logic        inOvervoltage,
    input  wire logic        regUndervoltage,
    input  wire logic        inOvercurrent,
    input  wire logic        chargePumpAbnormal,
    input  wire logic        chargePumpPartsMissing,
    input  wire logic        syncValidAtEnable,
    input  wire logic        syncLost,
    input  wire logic        boost_sync_input,
    input  wire logic        configLoadError,
    input  wire logic        fbOverLow,
    input  wire logic        fbOverHigh,
    input  wire logic        dischargeOver,
    input  wire logic        fbUnderUvp,
    // Initialization-time resistor detection
    input  wire logic        initDone,
    input  wire logic        stringResBad,
    input  wire logic [2:0]  stringResChannels,
    input  wire logic [7:0]  stringResCurrentMa,
    input  wire logic        modeResBad,
    input  wire logic [1:0]  modeResDimMode,
    input  wire logic [6:0]  modeResAddr,
    input  wire logic        boostFreqResBad,
    input  wire logic [11:0] boostFreqResKhz,
    input  wire logic        pwmFreqResBad,
    input  wire logic [11:0] pwmFreqResHz,
    // System conditions
    input  wire logic        enable,
    input  wire logic        brightnessNonzero,
    // Responses
    output logic             faultIrq,
    output logic             powerEnable,
    output logic             boostSwitchEnable,
    output logic             chargePumpEnable,
    output logic             useInternalClock,
    output logic             spreadSpectrumEnable,
    output logic [2:0]       ledChannels,
    output logic [7:0]       ledCurrentMa,
    output logic [1:0]       dimMode,
    output logic [6:0]       targetAddr,
    output logic [11:0]      boostFreqKhz,
    output logic [11:0]      pwmFreqHz
);
    import sbfm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [NumFlags-1:0] status_q;
    logic [NumFlags-1:0] irqEnable_q;
    logic [NumFlags-1:0] event_d;
    logic [NumFlags-1:0] clear_d;
    sbfm_state_e         state_q;
    // 24 bits cover the full 110 ms count
    logic [CntW-1:0]     recCnt_q;
    logic [CntW-1:0]     uvpCnt_q;
    logic                waitLevel_q;
    logic                ovHold_q;
    logic                ovpHighHold_q;
    logic                syncLost_q;
    logic                cpOff_q;
    logic                latched_q;
    logic                wbReq;
    logic                uvpQualified;
    logic                recoverFault;

    // Address and direction match; callers
    // handle the byte lanes themselves
    function automatic logic wr_hit(input logic [7:0] adr, input logic [7:0] off,
                                    input logic req, input logic we);
        return req && we && (adr == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Event sources
    assign uvpQualified = (uvpCnt_q >= CntW'(OcpQualCycles));
    // A held level re-sets its flag each cycle,
    // so a clear sticks only once it drops
    always_comb begin
        event_d             = '0;
        event_d[FInUv]      = inUndervoltage;
        event_d[FInOv]      = inOvervoltage;
        event_d[FRegUv]     = regUndervoltage;
        event_d[FInOc]      = inOvercurrent;
        event_d[FCp]        = chargePumpAbnormal | chargePumpPartsMissing;
        event_d[FCpMissing] = chargePumpPartsMissing;
        event_d[FSync]      = syncValidAtEnable & syncLost;
        event_d[FCrc]       = configLoadError;
        event_d[FOvpLow]    = fbOverLow;
        event_d[FOvpHigh]   = fbOverHigh | dischargeOver;
        event_d[FBstOc]     = uvpQualified;
        // Resistor flags sample only on the initialization strobe
        event_d[FStrRes]    = initDone & (state_q == SBFM_INIT) & stringResBad;
        event_d[FModeRes]   = initDone & (state_q == SBFM_INIT) & modeResBad;
        event_d[FFreqRes]   = initDone & (state_q == SBFM_INIT)
                              & (boostFreqResBad | pwmFreqResBad);
    end

    // Faults that send the device through the timed recovery state
    // Flag-only faults stay out of this set
    assign recoverFault = inOvervoltage | inOvercurrent | chargePumpAbnormal
                          | fbOverHigh | dischargeOver | uvpQualified;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait-free ack cycle, dropped the cycle after
    // Held stb gets ack every other cycle
    assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wbReq;
        end
    end

    // Read data is registered so it stands with ack
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wbReq && !wb_we_i) begin
            case (wb_adr_i)
                AddrStatus: wb_dat_o <= 32'(status_q);
                AddrEnable: wb_dat_o <= 32'(irqEnable_q);
                // Config word is full, so spread spectrum sits in the state word
                AddrConfig: wb_dat_o <= {useInternalClock,
                                         pwmFreqHz, boostFreqKhz, targetAddr};
                AddrState:  wb_dat_o <= {25'h0, spreadSpectrumEnable, latched_q, cpOff_q,
                                         boostSwitchEnable, logic'(state_q[2]), state_q[1:0]};
                default:    wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Clear strobes come from the write-only clear register, low two lanes
    // Lanes 2 and 3 carry no flag bits
    always_comb begin
        clear_d = '0;
        if (wr_hit(wb_adr_i, AddrClear, wbReq, wb_we_i)) begin
            clear_d[7:0] = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
            clear_d[NumFlags-1:8] = wb_sel_i[1] ? wb_dat_i[NumFlags-1:8] : 6'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky status: a new event beats a clear in the same cycle
    // Resistor flags only ever set from INIT
    always_ff @(posedge core_clk) begin
        if (reset) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~clear_d) | event_d;
        end
    end

    // Interrupt enable register
    // All ones at reset: no source starts hidden
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irqEnable_q <= EnableReset;
        end else if (wr_hit(wb_adr_i, AddrEnable, wbReq, wb_we_i)) begin
            if (wb_sel_i[0]) irqEnable_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) irqEnable_q[NumFlags-1:8] <= wb_dat_i[NumFlags-1:8];
        end
    end

    // Only interrupt-capable flags drive the pin; level until cleared
    // Flag-only bits never reach it, even enabled
    assign faultIrq = |(status_q & irqEnable_q & IrqCapable);

    ////////////////////////////////////////////////////////////////////////////
    // Feedback undervoltage qualification timer
    // Any break in the low level restarts it;
    // it saturates so it can never wrap
    always_ff @(posedge core_clk) begin
        if (reset) begin
            uvpCnt_q <= '0;
        end else if (!fbUnderUvp || state_q != SBFM_RUN) begin
            uvpCnt_q <= '0;
        end else if (!uvpQualified) begin
            uvpCnt_q <= uvpCnt_q + CntW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operating state: init, standby, run, timed recovery, hold-off
    // Only RECOVER counts; HOLD waits on levels
    // Brightness gates entry to RUN, not exit
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q  <= SBFM_INIT;
            recCnt_q <= '0;
        end else begin
            case (state_q)
                SBFM_INIT: begin
                    if (initDone) state_q <= SBFM_STANDBY;
                end
                SBFM_STANDBY: begin
                    // Level faults keep us in standby until they clear;
                    // live overvoltage too, as the latch lags a cycle
                    if (!inUndervoltage && !regUndervoltage && !ovHold_q && !inOvervoltage
                        && enable && brightnessNonzero) begin
                        state_q <= SBFM_RUN;
                    end
                end
                SBFM_RUN: begin
                    if (recoverFault) begin
                        state_q  <= SBFM_RECOVER;
                        recCnt_q <= '0;
                    end else if (inUndervoltage || regUndervoltage || !enable) begin
                        state_q <= SBFM_STANDBY;
                    end
                end
                SBFM_RECOVER: begin
                    if (recCnt_q >= CntW'(RecoveryCycles - 1)) begin
                        state_q <= SBFM_HOLD;
                    end else begin
                        recCnt_q <= recCnt_q + CntW'(1);
                    end
                end
                SBFM_HOLD: begin
                    // Overvoltage faults also wait for their level to drop
                    if (!waitLevel_q) state_q <= SBFM_STANDBY;
                end
                default: state_q <= SBFM_INIT;
            endcase
        end
    end

    // Overvoltage hold-off latches; released once the level falls
    // The high latch drops only in HOLD, so a
    // started recovery always runs to the end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ovHold_q      <= 1'b0;
            ovpHighHold_q <= 1'b0;
        end else begin
            if (inOvervoltage) ovHold_q <= 1'b1;
            else if (state_q != SBFM_RUN) ovHold_q <= 1'b0;
            if (fbOverHigh || dischargeOver) ovpHighHold_q <= 1'b1;
            else if (state_q == SBFM_HOLD) ovpHighHold_q <= 1'b0;
        end
    end
    assign waitLevel_q = ovHold_q | ovpHighHold_q | inOvervoltage;
    assign latched_q   = ovHold_q | ovpHighHold_q;

    // Power and boost gating; recovery forces all off
    // Low OVP pauses boost but stays in RUN
    assign powerEnable       = (state_q == SBFM_RUN);
    assign boostSwitchEnable = (state_q == SBFM_RUN) && !fbOverLow;

    ////////////////////////////////////////////////////////////////////////////
    // Charge pump disable, sticky until reset since the parts stay missing
    // A board repaired while powered stays off
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cpOff_q <= 1'b0;
        end else if (chargePumpPartsMissing) begin
            cpOff_q <= 1'b1;
        end
    end
    assign chargePumpEnable = !cpOff_q;

    // Sync clock fallback and spread-spectrum choice
    // Fallback is sticky until reset so the
    // boost clock never hops back and forth
    always_ff @(posedge core_clk) begin
        if (reset) begin
            syncLost_q           <= 1'b0;
            useInternalClock     <= 1'b0;
            spreadSpectrumEnable <= 1'b0;
        end else begin
            if (syncValidAtEnable && syncLost) syncLost_q <= 1'b1;
            useInternalClock     <= syncLost_q || !syncValidAtEnable;
            spreadSpectrumEnable <= syncLost_q && boost_sync_input;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration captured once at the end of initialization
    // Later changes on these inputs are ignored
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ledChannels  <= DefChannels;
            ledCurrentMa <= DefCurrentMa;
            dimMode      <= DimPhaseShift;
            targetAddr   <= DefAddr;
            boostFreqKhz <= DefBoostKhz;
            pwmFreqHz    <= DefPwmHz;
        end else if (initDone && state_q == SBFM_INIT) begin
            ledChannels  <= stringResBad ? DefChannels : stringResChannels;
            ledCurrentMa <= stringResBad ? DefCurrentMa : stringResCurrentMa;
            dimMode      <= modeResBad ? DimPhaseShift : modeResDimMode;
            targetAddr   <= modeResBad ? DefAddr : modeResAddr;
            boostFreqKhz <= boostFreqResBad ? DefBoostKhz : boostFreqResKhz;
            pwmFreqHz    <= pwmFreqResBad ? DefPwmHz : pwmFreqResHz;
        end
    end

    // Configuration load errors flag and interrupt; operation continues unchanged
    // so the sticky bit and its interrupt are the whole response.
endmodule

//--- hw/sbfm_pkg.sv
// Purpose: Shared constants for the supply and boost fault manager.
// Assumes: 125 MHz core clock, classic Wishbone register access.
// Notes:   Register offsets are byte addresses of 32-bit words.
package sbfm_pkg;
    // Clock and timing
    localparam int unsigned ClkHz        = 125_000_000;
    localparam int unsigned RecoveryMs   = 100;
    localparam int unsigned OcpQualMs    = 110;
    localparam int unsigned RecoveryCyc  = (ClkHz / 1000) * RecoveryMs;
    localparam int unsigned OcpQualCyc   = (ClkHz / 1000) * OcpQualMs;
    localparam int unsigned CntW         = 24;

    // Register map
    localparam logic [7:0] AddrStatus    = 8'h00;
    localparam logic [7:0] AddrClear     = 8'h04;
    localparam logic [7:0] AddrEnable    = 8'h08;
    localparam logic [7:0] AddrConfig    = 8'h0c;
    localparam logic [7:0] AddrState     = 8'h10;

    // Status bit positions
    localparam int unsigned NumFlags     = 14;
    localparam int unsigned FInUv        = 0;
    localparam int unsigned FInOv        = 1;
    localparam int unsigned FRegUv       = 2;
    localparam int unsigned FInOc        = 3;
    localparam int unsigned FCp          = 4;
    localparam int unsigned FCpMissing   = 5;
    localparam int unsigned FSync        = 6;
    localparam int unsigned FCrc         = 7;
    localparam int unsigned FOvpLow      = 8;
    localparam int unsigned FOvpHigh     = 9;
    localparam int unsigned FBstOc       = 10;
    localparam int unsigned FStrRes      = 11;
    localparam int unsigned FModeRes     = 12;
    localparam int unsigned FFreqRes     = 13;

    // Flags allowed to raise the interrupt
    localparam logic [13:0] IrqCapable   = 14'h06fe;
    localparam logic [13:0] EnableReset  = 14'h3fff;

    // Fallback configuration values
    localparam logic [2:0]  DefChannels  = 3'h6;
    localparam logic [7:0]  DefCurrentMa = 8'h96;
    localparam logic [6:0]  DefAddr      = 7'h2a;
    localparam logic [1:0]  DimPhaseShift = 2'h0;
    localparam logic [11:0] DefBoostKhz  = 12'h190;
    localparam logic [11:0] DefPwmHz     = 12'h131;

    // Operating state seen by this block
    typedef enum logic [2:0] {
        SBFM_INIT     = 3'b000,
        SBFM_STANDBY  = 3'b001,
        SBFM_RUN      = 3'b010,
        SBFM_RECOVER  = 3'b011,
        SBFM_HOLD     = 3'b100
    } sbfm_state_e;
endpackage

//--- tb/sbfm_checker_assertions.sv
// Purpose: Port-level assertions for the supply and boost fault manager.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound to the design top; judges design outputs only.
`timescale 1ns/1ps
module sbfm_checker #(
    parameter int unsigned OcpQualCycles = 30
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic inOvervoltage,
    input wire logic inOvercurrent,
    input wire logic chargePumpPartsMissing,
    input wire logic syncValidAtEnable,
    input wire logic syncLost,
    input wire logic fbOverLow,
    input wire logic fbUnderUvp,
    input wire logic faultIrq,
    input wire logic powerEnable,
    input wire logic boostSwitchEnable,
    input wire logic chargePumpEnable,
    input wire logic useInternalClock
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////
    // RUN cycles with feedback low; saturates so a long stall cannot wrap
    logic [7:0] uvpCnt_q;
    always_ff @(posedge core_clk) begin
        if (reset || !fbUnderUvp || !powerEnable) begin
            uvpCnt_q <= 8'h00;
        end else if (uvpCnt_q != 8'hff) begin
            uvpCnt_q <= uvpCnt_q + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////
    AST_ACK_TAKEN: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged after one cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |-> $past(wb_stb_i) ##1 !wb_ack_o)
        else $error("acknowledge without request or held too long");
    AST_OV_STANDBY: assert property (inOvervoltage |=> !powerEnable)
        else $error("power stayed on during input overvoltage");
    AST_RECOVER_HOLD: assert property ($fell(powerEnable) && $past(inOvercurrent)
        |-> !powerEnable [*8]) else $error("recovery ended too early");
    AST_CP_OFF: assert property (chargePumpPartsMissing || !chargePumpEnable
        |=> !chargePumpEnable) else $error("charge pump enabled after parts missing");
    AST_SYNC_FALLBACK: assert property (syncValidAtEnable && syncLost
        |-> ##[1:2] useInternalClock) else $error("no fallback to internal clock");
    AST_OVP_LOW: assert property (fbOverLow |-> !boostSwitchEnable)
        else $error("boost switching during low overvoltage");
    AST_BOOST_QUAL: assert property (uvpCnt_q <= OcpQualCycles + 2)
        else $error("boost overcurrent not declared in time");
    AST_IRQ_HELD: assert property ($fell(faultIrq) |-> wb_ack_o && wb_we_i)
        else $error("interrupt dropped without a host write");
endmodule
bind sbfm_fault_manager sbfm_checker #(.OcpQualCycles(OcpQualCycles)) i_chk (.*);

//--- tb/sbfm_host_model.sv
// Purpose: Host processor model servicing the fault manager registers.
// Assumes: Classic Wishbone single cycles on core_clk.
// Notes:   Waits for ack without limit; the bench watchdog ends hangs.
`timescale 1ns/1ps
module sbfm_host_model (
    input  wire logic        core_clk,
    input  wire logic        wbAck,
    input  wire logic [31:0] wbDatIn,
    output logic             wbCyc,
    output logic             wbStb,
    output logic             wbWe,
    output logic [7:0]       wbAdr,
    output logic [3:0]       wbSel,
    output logic [31:0]      wbDat
);
    // Bus idle at time zero
    initial begin
        {wbCyc, wbStb, wbWe} = 3'h0;
        {wbAdr, wbSel, wbDat} = 44'h0;
    end
    ////////////////////////////////////////////////////////////
    // One classic cycle, held until ack is sampled, then released
    task automatic access(input logic [7:0] adr, input logic we, input logic [31:0] wdat,
                          output logic [31:0] rdat);
        @(posedge core_clk);
        {wbCyc, wbStb, wbWe} <= {2'h3, we};
        wbAdr <= adr;
        wbSel <= 4'hf;
        wbDat <= wdat;
        do @(posedge core_clk); while (wbAck !== 1'b1);
        rdat = wbDatIn;
        {wbCyc, wbStb, wbWe} <= 3'h0;
        wbAdr <= ~adr; // Released lines must not keep showing the old request
        wbDat <= ~wdat;
    endtask
endmodule

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the supply and boost fault manager.
// Assumes: Recovery and qualification counts shortened by parameters.
// Notes:   Host model drives the bus; detector levels are driven here.
`timescale 1ns/1ps
module tb_top;
    import sbfm_pkg::*;
    localparam int RecCyc = 20;
    localparam int QualCyc = 30;
    localparam logic [47:0] CfgExp = {4'h0, DefChannels, DefCurrentMa, DimPhaseShift,
                                      DefAddr, 12'h0c8, DefPwmHz};
    // Detector pulse beside the status it must leave behind
    localparam logic [24:0] Rows [11] = '{{11'h001, 14'h0001}, {11'h002, 14'h0002},
        {11'h004, 14'h0004}, {11'h008, 14'h0008}, {11'h010, 14'h0010}, {11'h020, 14'h0030},
        {11'h040, 14'h0040}, {11'h080, 14'h0080}, {11'h100, 14'h0100}, {11'h200, 14'h0200},
        {11'h400, 14'h0200}};
    logic        core_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, faultIrq, initDone;
    logic        inUndervoltage, inOvervoltage, regUndervoltage, inOvercurrent, syncLost;
    logic        chargePumpAbnormal, chargePumpPartsMissing, configLoadError, fbOverLow;
    logic        fbOverHigh, dischargeOver, fbUnderUvp, syncValidAtEnable, boost_sync_input;
    logic        stringResBad, modeResBad, boostFreqResBad, pwmFreqResBad, enable;
    logic        brightnessNonzero, powerEnable, boostSwitchEnable, chargePumpEnable;
    logic        useInternalClock, spreadSpectrumEnable;
    logic [1:0]  modeResDimMode, dimMode;
    logic [2:0]  stringResChannels, ledChannels;
    logic [3:0]  wb_sel_i;
    logic [6:0]  modeResAddr, targetAddr;
    logic [7:0]  wb_adr_i, ledCurrentMa, stringResCurrentMa;
    logic [10:0] det;
    logic [11:0] boostFreqResKhz, pwmFreqResHz, boostFreqKhz, pwmFreqHz;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [47:0] cfgOut;
    int          mismatches, compares, n;
    // Detector levels gathered so one table row drives one fault
    assign {dischargeOver, fbOverHigh, fbOverLow, configLoadError, syncLost,
            chargePumpPartsMissing, chargePumpAbnormal, inOvercurrent,
            regUndervoltage, inOvervoltage, inUndervoltage} = det;
    assign cfgOut = {4'h0, ledChannels, ledCurrentMa, dimMode, targetAddr, boostFreqKhz, pwmFreqHz};
    ////////////////////////////////////////////////////////////
    sbfm_fault_manager #(.RecoveryCycles(RecCyc), .OcpQualCycles(QualCyc)) i_dut (.*);
    sbfm_host_model i_host (.core_clk, .wbAck(wb_ack_o), .wbDatIn(wb_dat_o), .wbCyc(wb_cyc_i),
        .wbStb(wb_stb_i), .wbWe(wb_we_i), .wbAdr(wb_adr_i), .wbSel(wb_sel_i), .wbDat(wb_dat_i));
    // 125 MHz core clock
    always #4 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One-cycle detector pulse, then settle so sampled outputs are stable
    task automatic pulse(input logic [10:0] d);
        @(posedge core_clk);
        det <= d;
        @(posedge core_clk);
        det <= 11'h000;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic waitRun();
        for (int k = 0; k < 400 && powerEnable !== 1'b1; k++) @(negedge core_clk);
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Main sequence: init choices, table of faults, then the awkward cases
    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        det = 11'h000;
        {mismatches, compares} = {32'h0, 32'h0};
        {fbUnderUvp, boost_sync_input, initDone} = 3'h0;
        {syncValidAtEnable, enable, brightnessNonzero} = 3'h7;
        {stringResBad, modeResBad, boostFreqResBad, pwmFreqResBad} = 4'hd;
        {stringResChannels, stringResCurrentMa, modeResDimMode, modeResAddr} = 20'h44056;
        {boostFreqResKhz, pwmFreqResHz} = {12'h0c8, 12'h0fa};
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        initDone <= 1'b1;
        repeat (3) @(posedge core_clk);
        {stringResBad, modeResBad, boostFreqResBad, pwmFreqResBad} <= 4'h2;
        i_host.access(AddrStatus, 1'b1, 32'h0, rd);
        i_host.access(AddrStatus, 1'b0, 32'h0, rd);
        chk("status", 48'h3800, 48'(rd));
        chk("config", CfgExp, cfgOut);
        chk("irq", 48'h0, 48'(faultIrq));
        i_host.access(AddrEnable, 1'b0, 32'h0, rd);
        chk("enableReset", 48'h3fff, 48'(rd));
        i_host.access(8'h1c, 1'b0, 32'h0, rd);
        chk("unmapped", 48'h0, 48'(rd));
        i_host.access(AddrClear, 1'b1, 32'h3fff, rd);
        for (int i = 0; i < 11; i++) begin
            pulse(Rows[i][24:14]);
            chk("irq", 48'(|(Rows[i][13:0] & IrqCapable)), 48'(faultIrq));
            i_host.access(AddrStatus, 1'b0, 32'h0, rd);
            chk("status", 48'(Rows[i][13:0]), 48'(rd));
            i_host.access(AddrClear, 1'b1, 32'h3fff, rd);
            @(negedge core_clk);
            chk("irqCleared", 48'h0, 48'(faultIrq));
        end
        chk("pumpOff", 48'h0, 48'(chargePumpEnable));
        @(posedge core_clk);
        boost_sync_input <= 1'b1;
        repeat (3) @(negedge core_clk);
        chk("fallback", 48'h3, 48'({useInternalClock, spreadSpectrumEnable}));
        @(posedge core_clk);
        boost_sync_input <= 1'b0;
        repeat (3) @(negedge core_clk);
        chk("spreadOff", 48'h2, 48'({useInternalClock, spreadSpectrumEnable}));
        i_host.access(AddrEnable, 1'b1, 32'h0, rd);
        pulse(11'h080);
        chk("masked", 48'h0, 48'(faultIrq));
        i_host.access(AddrEnable, 1'b1, 32'h3fff, rd);
        @(negedge core_clk);
        chk("unmasked", 48'h1, 48'(faultIrq));
        waitRun();
        @(posedge core_clk);
        det <= 11'h100;
        @(negedge core_clk);
        chk("boostPaused", 48'h2, 48'({powerEnable, boostSwitchEnable}));
        pulse(11'h008);
        for (n = 2; n < 200 && powerEnable !== 1'b1; n++) @(negedge core_clk);
        chk("recoverLen", 48'h1, 48'(n >= RecCyc && n <= RecCyc + 8));
        waitRun();
        @(posedge core_clk);
        brightnessNonzero <= 1'b0;
        pulse(11'h010);
        repeat (3 * RecCyc) @(negedge core_clk);
        chk("noRestart", 48'h0, 48'(powerEnable));
        @(posedge core_clk);
        brightnessNonzero <= 1'b1;
        waitRun();
        chk("restart", 48'h1, 48'(powerEnable));
        @(posedge core_clk);
        fbUnderUvp <= 1'b1;
        for (n = 0; n < 200 && powerEnable === 1'b1; n++) @(negedge core_clk);
        @(posedge core_clk);
        fbUnderUvp <= 1'b0;
        chk("qualLen", 48'h1, 48'(n >= QualCyc - 1 && n <= QualCyc + 3));
        i_host.access(AddrStatus, 1'b0, 32'h0, rd);
        chk("boostOcFlag", 48'h1, 48'(rd[FBstOc]));
        stop_test();
    end
    // Watchdog: the sequence needs a few thousand cycles at most
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        stop_test();
    end
endmodule
